/* rtl/stereo_audio_dac_frontend.sv */
/*
  stereo delta-sigma converter front end: queues, default substitution,
  format handling, 256x linear interpolation, second-order modulators.
  assumes the auxiliary oscillator clock is clk_sys and the idle request
  and control bits are stable levels synchronous to it.
*/
// How it works
// - two independent channels, left and right, each with its own stream
// - each channel buffers samples in a four entry queue
// - empty queue at sample time uses the default sample register
// - sixteen bit samples accepted from processor and from dma ports
// - signedness select 1 means two's complement, 0 unsigned
// - unsigned maps ffff high, 8000 mid, 0000 low
// - signed maps 7fff high, 0000 mid, 8000 low
// - interpolator upsamples each channel by 256
// - interpolation filtering shapes noise above the audio band
// - second-order delta-sigma modulator produces the output bit stream
// - converter clock divided from auxiliary clock by 7-bit field
// - one sample per channel every 256 converter clocks
// - divider is field plus one, 1 to 128, reset divide by 6
// - per-channel queue full and empty flags are readable
// - request type bit: 1 service on empty, 0 on not full
// - idle stop select halts the converter clock while the device idles; queues still accept writes
`timescale 1ns/1ps
module stereo_audio_dac_frontend
  import audio_dac_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
)(
  input wire logic clk_sys, // auxiliary clock
  input wire logic rst_b, // sync reset, low
  input wire logic enable, // module enable
  input wire logic idle_stop_select, // halt while idle
  input wire logic device_idle, // device in idle mode
  input wire logic signedness_select, // 1 signed, 0 unsigned
  input wire logic [6:0] converter_clock_divider, // divide by n+1
  input wire logic [15:0] default_sample_register, // empty fill value
  input wire logic left_service_request_type, // 1 empty, 0 not full
  input wire logic right_service_request_type, // 1 empty, 0 not full
  input wire logic [15:0] cpu_left_data, // cpu left word
  input wire logic cpu_left_write, // cpu left strobe
  input wire logic [15:0] cpu_right_data, // cpu right word
  input wire logic cpu_right_write, // cpu right strobe
  input wire logic [15:0] dma_left_data, // dma left word
  input wire logic dma_left_valid, // dma left valid
  output logic dma_left_ready, // dma left ready
  input wire logic [15:0] dma_right_data, // dma right word
  input wire logic dma_right_valid, // dma right valid
  output logic dma_right_ready, // dma right ready
  output logic left_queue_full_flag, // left full
  output logic left_queue_empty_flag, // left empty
  output logic right_queue_full_flag, // right full
  output logic right_queue_empty_flag, // right empty
  output logic left_service_request, // left wants data
  output logic right_service_request, // right wants data
  output logic converter_tick, // one converter clock pulse
  output logic left_bitstream, // left modulator bit
  output logic right_bitstream // right modulator bit
);
  // ******************************************************
  // input side
  // ******************************************************
  logic [1:0] wr_valid;
  logic [15:0] wr_data [2];
  logic [1:0] in_ready;
  logic [1:0] q_full;
  logic [1:0] q_empty;
  logic [1:0] q_pop;
  logic [15:0] q_head [2];
  logic [1:0] req_type;
  logic running;
  logic tick;
  logic sample_strobe;

  // cpu strobe has priority; dma ready falls a cycle later, so a dma word taken in that cycle is lost
  assign wr_valid[0] = cpu_left_write || dma_left_valid;
  assign wr_valid[1] = cpu_right_write || dma_right_valid;
  assign wr_data[0] = cpu_left_write ? cpu_left_data : dma_left_data;
  assign wr_data[1] = cpu_right_write ? cpu_right_data : dma_right_data;
  assign req_type = {right_service_request_type, left_service_request_type};
  assign running = enable && !(idle_stop_select && device_idle);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      sample_queue #(
        .WIDTH(SAMPLE_W),
        .DEPTH(DEPTH)
      ) u_queue (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_data(wr_data[ch]),
        .in_valid(wr_valid[ch]),
        .in_ready(in_ready[ch]),
        .out_data(q_head[ch]),
        .out_valid(),
        .out_ready(q_pop[ch]),
        .full(q_full[ch]),
        .empty(q_empty[ch])
      );
      assign q_pop[ch] = sample_strobe;
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      left_queue_full_flag <= 1'b0;
      left_queue_empty_flag <= 1'b1;
      right_queue_full_flag <= 1'b0;
      right_queue_empty_flag <= 1'b1;
      left_service_request <= 1'b0;
      right_service_request <= 1'b0;
      dma_left_ready <= 1'b0;
      dma_right_ready <= 1'b0;
    end
    else
    begin
      left_queue_full_flag <= q_full[0];
      left_queue_empty_flag <= q_empty[0];
      right_queue_full_flag <= q_full[1];
      right_queue_empty_flag <= q_empty[1];
      left_service_request <= req_type[0] ? q_empty[0] : !q_full[0];
      right_service_request <= req_type[1] ? q_empty[1] : !q_full[1];
      // registered ready is conservative: held low for a cycle after any write
      dma_left_ready <= in_ready[0] && !cpu_left_write && !wr_valid[0];
      dma_right_ready <= in_ready[1] && !cpu_right_write && !wr_valid[1];
    end
  end

  // ******************************************************
  // converter clock and sample timing
  // ******************************************************
  logic [DIV_W-1:0] div_q;
  logic [PHASE_W-1:0] phase_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !running)
    begin
      div_q <= '0;
    end
    else if (div_q >= converter_clock_divider)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tick = running && (div_q >= converter_clock_divider);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      phase_q <= '0;
    end
    else if (tick)
    begin
      phase_q <= phase_q + 1'b1;
    end
  end

  assign sample_strobe = tick && (phase_q == '1);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      converter_tick <= 1'b0;
    end
    else
    begin
      converter_tick <= tick;
    end
  end

  // ******************************************************
  // format, interpolation, modulation per channel
  // ******************************************************
  logic signed [15:0] cur_q [2];
  logic signed [15:0] prev_q [2];
  logic signed [ACC_W-1:0] interp_q [2];
  logic signed [ACC_W-1:0] int1_q [2];
  logic signed [ACC_W-1:0] int2_q [2];
  logic [1:0] bit_q;

  function automatic logic signed [15:0] to_signed(input logic [15:0] s,
                                                   input logic fmt);
    // unsigned data is offset binary; flipping msb gives two's complement
    return fmt ? s : (s ^ SIGN_FLIP);
  endfunction : to_signed

  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_mod
      logic [15:0] next_raw;
      logic signed [ACC_W-1:0] fb;
      logic signed [ACC_W-1:0] step;
      logic signed [ACC_W-1:0] drive;
      logic quant;
      // default fills in only when the queue has nothing to give
      assign next_raw = q_empty[ch] ? default_sample_register
                                    : q_head[ch];
      // quantise the present second integrator: an extra loop delay
      // here would make the second-order loop unstable
      assign quant = !int2_q[ch][ACC_W-1];
      assign fb = quant ? ACC_W'(signed'(32'sh0080_0000))
                        : ACC_W'(-(32'sh0080_0000));
      // input held to half the feedback level; a 1-bit second-order
      // loop overloads near full scale, so 6 dB of range is traded away
      assign drive = interp_q[ch] >>> 1;
      // linear ramp is a first-order hold; its sinc^2 response with the
      // second-order loop pushes quantisation noise out of band
      assign step = ACC_W'(cur_q[ch]) - ACC_W'(prev_q[ch]);

      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
        begin
          cur_q[ch] <= '0;
          prev_q[ch] <= '0;
          interp_q[ch] <= '0;
        end
        else if (sample_strobe)
        begin
          prev_q[ch] <= cur_q[ch];
          cur_q[ch] <= to_signed(next_raw, signedness_select);
          interp_q[ch] <= ACC_W'(cur_q[ch]) <<< PHASE_W;
        end
        else if (tick)
        begin
          interp_q[ch] <= interp_q[ch] + step;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
        begin
          int1_q[ch] <= '0;
          int2_q[ch] <= '0;
          bit_q[ch] <= 1'b0;
        end
        else if (tick)
        begin
          int1_q[ch] <= int1_q[ch] + drive - fb;
          int2_q[ch] <= int2_q[ch] + int1_q[ch] - (fb <<< 1);
          bit_q[ch] <= quant;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      left_bitstream <= 1'b0;
      right_bitstream <= 1'b0;
    end
    else
    begin
      left_bitstream <= bit_q[0];
      right_bitstream <= bit_q[1];
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  property p_empty_after_reset;
    @(posedge clk_sys) !rst_b |=>
      left_queue_empty_flag && right_queue_empty_flag;
  endproperty
  a_empty_after_reset: assert property (p_empty_after_reset)
    else $error("empty flags not set after reset");

  property p_full_flag;
    @(posedge clk_sys) disable iff (!rst_b)
      q_full[0] |=> left_queue_full_flag;
  endproperty
  a_full_flag: assert property (p_full_flag)
    else $error("left full flag missed");

  property p_req_type;
    @(posedge clk_sys) disable iff (!rst_b)
      (left_service_request_type && !q_empty[0]) |=> !left_service_request;
  endproperty
  a_req_type: assert property (p_req_type)
    else $error("left request on non-empty in empty mode");

  property p_idle_halt;
    @(posedge clk_sys) disable iff (!rst_b)
      (idle_stop_select && device_idle) |=> !converter_tick;
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("converter ran while idle stopped");

  property p_div_spacing;
    @(posedge clk_sys) disable iff (!rst_b)
      (tick && converter_clock_divider == 7'h01 && running) |=> !tick;
  endproperty
  a_div_spacing: assert property (p_div_spacing)
    else $error("divide by two ticked twice in a row");

  property p_default_fill;
    @(posedge clk_sys) disable iff (!rst_b)
      (sample_strobe && q_empty[0] && signedness_select) |=>
        cur_q[0] == $past(default_sample_register);
  endproperty
  a_default_fill: assert property (p_default_fill)
    else $error("default sample not substituted");

  property p_unsigned_mid;
    @(posedge clk_sys) disable iff (!rst_b)
      (sample_strobe && !signedness_select &&
       g_mod[0].next_raw == 16'h8000) |=> cur_q[0] == 16'sh0000;
  endproperty
  a_unsigned_mid: assert property (p_unsigned_mid)
    else $error("unsigned midpoint not mapped to zero");

  property p_full_keeps;
    @(posedge clk_sys) disable iff (!rst_b)
      (q_full[0] && wr_valid[0] && !q_pop[0]) |=> q_full[0];
  endproperty
  a_full_keeps: assert property (p_full_keeps)
    else $error("full queue changed on discarded write");

  property p_strobe_wrap;
    @(posedge clk_sys) disable iff (!rst_b)
      sample_strobe |=> phase_q == '0;
  endproperty
  a_strobe_wrap: assert property (p_strobe_wrap)
    else $error("sample taken off the 256 tick boundary");

  c_left_fill: cover property (@(posedge clk_sys) q_full[0]);
  c_default_used: cover property (@(posedge clk_sys)
    sample_strobe && q_empty[1]);
  c_idle_stop: cover property (@(posedge clk_sys)
    idle_stop_select && device_idle && enable);
  c_right_full: cover property (@(posedge clk_sys)
    right_queue_full_flag && !right_service_request);
endmodule : stereo_audio_dac_frontend

/* rtl/audio_dac_pkg.sv */
/*
  constants shared by the stereo converter front end and its sample queue.
  assumes a single clk_sys domain and synchronous active-low reset.
*/
package audio_dac_pkg;
  localparam int SAMPLE_W = 16;
  localparam int QUEUE_DEPTH = 4;
  localparam int DIV_W = 7;
  localparam logic [6:0] DIV_RESET = 7'h05;
  localparam int OSR = 256;
  localparam int PHASE_W = 8;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;
  localparam logic [15:0] DEFAULT_RESET = 16'h0000;
  localparam int ACC_W = 30;
endpackage : audio_dac_pkg

/* rtl/sample_queue.sv */
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock; reset empties it.
*/
`timescale 1ns/1ps
module sample_queue
  import audio_dac_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
)(
  input wire logic clk_sys, // clock
  input wire logic rst_b, // sync reset, low
  input wire logic [WIDTH-1:0] in_data, // write word
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // not empty
  input wire logic out_ready, // pop
  output logic full, // full flag
  output logic empty // empty flag
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign empty = (cnt_q == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_q];
  // writes into a full queue are dropped, queued words stay intact
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : sample_queue

/* tb/dma_source.sv */
/*
  behavioural dma engine that feeds one converter channel, word by word.
  assumes the front end samples valid and data on rising clk_sys edges.
*/
`timescale 1ns/1ps
module dma_source (
  input wire logic clk_sys, // clock
  input wire logic ready, // front end ready
  output logic [15:0] data, // sample word
  output logic valid, // word offered
  output logic stalled // gave up waiting
);
  initial
  begin
    data = 16'h5a5a;
    valid = 1'b0;
    stalled = 1'b0;
  end
  // ****************************************
  // offer held until ready is seen at a rising edge, or for 64 edges before stalling
  // ****************************************
  task automatic send(input logic [15:0] w);
    int n;
    @(negedge clk_sys);
    data = w;
    valid = 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ready !== 1'b1 && n < 64);
    if (ready !== 1'b1)
      stalled = 1'b1;
    @(negedge clk_sys);
    valid = 1'b0;
    // a released bus shows no stale word
    data = ~w;
  endtask : send
endmodule : dma_source

/* tb/tb.sv */
/*
  self-checking bench for the stereo converter front end.
  assumes clk_sys at 25 MHz and two dma_source partners on the dma ports.
*/
`timescale 1ns/1ps
module tb;
  import audio_dac_pkg::*;
  localparam int LIMIT = 30000;
  logic clk_sys, rst_b, enable, idle_stop_select, device_idle;
  logic signedness_select;
  logic [6:0] converter_clock_divider;
  logic [15:0] default_sample_register, cpu_left_data, cpu_right_data;
  logic left_service_request_type, right_service_request_type;
  logic [15:0] dma_left_data, dma_right_data;
  logic cpu_left_write, cpu_right_write, dma_left_valid, dma_right_valid;
  logic dma_left_ready, dma_right_ready, left_stalled, right_stalled;
  logic left_queue_full_flag, left_queue_empty_flag;
  logic right_queue_full_flag, right_queue_empty_flag;
  logic left_service_request, right_service_request;
  logic converter_tick, left_bitstream, right_bitstream;
  int err_count, checks, cyc, n, ones_l, ones_r;
  int divs[5] = '{0, 1, 2, 5, 127};
  logic fmts[6] = '{0, 0, 0, 1, 1, 1};
  logic [15:0] vals[6] = '{16'hffff, 16'h8000, 16'h0000, 16'h7fff,
    16'h0000, 16'h8000};
  int los[6] = '{358, 230, 102, 358, 230, 102};
  int his[6] = '{410, 282, 154, 410, 282, 154};

  stereo_audio_dac_frontend #(.DEPTH(4)) stereo_audio_dac_frontend_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .enable(enable),
    .idle_stop_select(idle_stop_select), .device_idle(device_idle),
    .signedness_select(signedness_select),
    .converter_clock_divider(converter_clock_divider),
    .default_sample_register(default_sample_register),
    .left_service_request_type(left_service_request_type),
    .right_service_request_type(right_service_request_type),
    .cpu_left_data(cpu_left_data), .cpu_left_write(cpu_left_write),
    .cpu_right_data(cpu_right_data), .cpu_right_write(cpu_right_write),
    .dma_left_data(dma_left_data), .dma_left_valid(dma_left_valid),
    .dma_left_ready(dma_left_ready), .dma_right_data(dma_right_data),
    .dma_right_valid(dma_right_valid), .dma_right_ready(dma_right_ready),
    .left_queue_full_flag(left_queue_full_flag),
    .left_queue_empty_flag(left_queue_empty_flag),
    .right_queue_full_flag(right_queue_full_flag),
    .right_queue_empty_flag(right_queue_empty_flag),
    .left_service_request(left_service_request),
    .right_service_request(right_service_request),
    .converter_tick(converter_tick), .left_bitstream(left_bitstream),
    .right_bitstream(right_bitstream));
  dma_source dma_source_inst (.clk_sys(clk_sys), .ready(dma_left_ready),
    .data(dma_left_data), .valid(dma_left_valid), .stalled(left_stalled));
  dma_source dma_source_r_inst (.clk_sys(clk_sys), .ready(dma_right_ready),
    .data(dma_right_data), .valid(dma_right_valid), .stalled(right_stalled));

  // ****************************************
  // clock, timeout and report
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_eq
  task automatic check_range(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : check_range
  // flags packed as left_queue_full_flag left_queue_empty_flag right_queue_full_flag right_queue_empty_flag lreq rreq
  task automatic check_flags(input logic [5:0] exp);
    check_eq({10'h000, left_queue_full_flag, left_queue_empty_flag,
      right_queue_full_flag, right_queue_empty_flag,
      left_service_request, right_service_request}, {10'h000, exp});
  endtask : check_flags
  task automatic cpu_write(input logic right, input logic [15:0] w);
    @(negedge clk_sys);
    cpu_right_data = w;
    cpu_left_data = w;
    cpu_right_write = right;
    cpu_left_write = ~right;
    @(negedge clk_sys);
    cpu_left_write = 1'b0;
    cpu_right_write = 1'b0;
  endtask : cpu_write
  task automatic wait_cycles(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : wait_cycles
  task automatic count_ones(input int k);
    n = 0;
    ones_l = 0;
    ones_r = 0;
    repeat (k)
    begin
      @(negedge clk_sys);
      n += (converter_tick === 1'b1);
      ones_l += (left_bitstream === 1'b1);
      ones_r += (right_bitstream === 1'b1);
    end
  endtask : count_ones

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    err_count = 0;
    checks = 0;
    cyc = 0;
    rst_b = 1'b0;
    enable = 1'b1;
    idle_stop_select = 1'b1;
    device_idle = 1'b1;
    signedness_select = 1'b0;
    converter_clock_divider = DIV_RESET;
    default_sample_register = 16'h8000;
    left_service_request_type = 1'b0;
    right_service_request_type = 1'b1;
    cpu_left_data = 16'h0000;
    cpu_right_data = 16'h0000;
    cpu_left_write = 1'b0;
    cpu_right_write = 1'b0;
    wait_cycles(16);
    check_flags(6'b010100);
    rst_b = 1'b1;
    wait_cycles(3);
    check_flags(6'b010111);
    $display("test reset done");
    count_ones(40);
    check_eq(n[15:0], 16'h0000);
    device_idle = 1'b1;
    idle_stop_select = 1'b0;
    foreach (divs[i])
    begin
      converter_clock_divider = divs[i][6:0];
      wait_cycles(130);
      count_ones(4 * (divs[i] + 1));
      check_eq(n[15:0], 16'h0004);
    end
    $display("test divider done");
    enable = 1'b0;
    wait_cycles(4);
    repeat (3) cpu_write(1'b0, 16'h1234);
    wait_cycles(3);
    check_flags(6'b000111);
    dma_source_inst.send(16'h4321);
    cpu_write(1'b0, 16'hdead);
    for (int i = 0; i < 4; i++)
      dma_source_r_inst.send(16'h0100 + i[15:0]);
    wait_cycles(3);
    check_flags(6'b101000);
    left_service_request_type = 1'b1;
    right_service_request_type = 1'b0;
    wait_cycles(3);
    check_flags(6'b101000);
    check_eq({15'h0000, left_stalled | right_stalled}, 16'h0000);
    $display("test fill done");
    converter_clock_divider = 7'h00;
    enable = 1'b1;
    n = 0;
    while (left_queue_full_flag !== 1'b0 && n < 2000)
    begin
      wait_cycles(1);
      n++;
    end
    n = 0;
    while (left_queue_empty_flag !== 1'b1 && n < 2000)
    begin
      wait_cycles(1);
      n++;
    end
    check_eq(n[15:0], 16'h0300);
    wait_cycles(3);
    check_flags(6'b010111);
    $display("test drain done");
    foreach (vals[i])
    begin
      signedness_select = fmts[i];
      default_sample_register = vals[i];
      wait_cycles(800);
      count_ones(512);
      check_range(ones_l, los[i], his[i]);
      check_range(ones_r, los[i], his[i]);
    end
    $display("test format done");
    finish_test();
  end
endmodule : tb
